// File: hdl/sbat_defs.svh
// Constants for the bank-access timing block
`ifndef SBAT_DEFS_SVH
`define SBAT_DEFS_SVH

// Link clock and timing figures
`define SBAT_LINK_PERIOD_NS 48
`define SBAT_ROW_TO_COLUMN_DELAY_NS 18
`define SBAT_ROW_TO_COLUMN_DELAY_CYC ((`SBAT_ROW_TO_COLUMN_DELAY_NS + `SBAT_LINK_PERIOD_NS - 1) / `SBAT_LINK_PERIOD_NS)
`define SBAT_RL 10
`define SBAT_WL_A 6
`define SBAT_WL_B 8
`define SBAT_BL 8
`define SBAT_BURST_CYC 4

// Widths
`define SBAT_BANKS 8
`define SBAT_CA_W 10
`define SBAT_PAIR_W 16
`define SBAT_WORD_W 64
`define SBAT_MEM_DEPTH 64
`define SBAT_BEAT_LAST 2'h3
`define SBAT_ERR_W 8

// Command/address field positions
`define SBAT_CA_OP0 0
`define SBAT_CA_OP1 1
`define SBAT_CA_OP2 2
`define SBAT_CA_OP3 3
`define SBAT_CA_AB 4
`define SBAT_CA_COLR_LO 5
`define SBAT_CA_COLR_HI 6
`define SBAT_CA_BA_LO 7
`define SBAT_CA_BA_HI 9
`define SBAT_CA_COLF_LO 1
`define SBAT_CA_COLF_HI 9
`define SBAT_GRP_LO 3
`define SBAT_GRP_HI 5

`endif

// File: hdl/sbat_pkg.sv
// Types for the bank-access timing block
package sbat_pkg;
   typedef enum logic [2:0] {
      SBAT_CMD_NOP,
      SBAT_CMD_ACT,
      SBAT_CMD_RD,
      SBAT_CMD_WR,
      SBAT_CMD_PRE
   } sbat_cmd_t;
   typedef enum logic [1:0] {
      SBAT_RD_IDLE,
      SBAT_RD_PREAMBLE,
      SBAT_RD_DATA
   } sbat_rd_state_t;
   typedef logic [2:0] sbat_bank_t;
   typedef logic [2:0] sbat_grp_t;
   typedef logic [5:0] sbat_maddr_t;
   typedef logic [10:0] sbat_col_t;
   typedef logic [3:0] sbat_timer_t;
   typedef logic [1:0] sbat_beat_t;
endpackage : sbat_pkg

// File: hdl/sbat_sync.sv
// Two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
`default_nettype none

module sbat_sync #(
   parameter int W = 1
) (
   // Destination clock
   input wire logic clk_in,
   // Data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk_in) begin
      meta_ff <= d_in;
      q_out <= meta_ff;
   end
endmodule : sbat_sync

`default_nettype wire

// File: hdl/sbat_bank.sv
// One bank: open state and activate-to-column timer
`timescale 1ns/1ps
`default_nettype none
`include "sbat_defs.svh"

module sbat_bank
   import sbat_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Commands hitting this bank
   input wire logic act_in,
   input wire logic pre_in,
   // State
   output logic open_out,
   output logic ready_out
);
   sbat_timer_t rcd_cnt_ff;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         open_out <= 1'b0;
      end else if (act_in) begin
         open_out <= 1'b1;
      end else if (pre_in) begin
         open_out <= 1'b0;
      end
   end

   // Counts down the activate-to-column delay
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rcd_cnt_ff <= '0;
      end else if (act_in) begin
         rcd_cnt_ff <= sbat_timer_t'(`SBAT_ROW_TO_COLUMN_DELAY_CYC - 1);
      end else if (rcd_cnt_ff != '0) begin
         rcd_cnt_ff <= rcd_cnt_ff - 1'b1;
      end
   end

   assign ready_out = open_out && (rcd_cnt_ff == '0);
endmodule : sbat_bank

`default_nettype wire

// File: hdl/sbat_top.sv
// Bank-access timing block: command decode, bank state, read and write bursts
`timescale 1ns/1ps
`default_nettype none
`include "sbat_defs.svh"

module sbat_top
   import sbat_pkg::*;
(
   // Core clock domain
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic wl_set_b_in,
   output logic [`SBAT_BANKS-1:0] bank_open_out,
   output logic [`SBAT_ERR_W-1:0] proto_err_cnt_out,
   // Link command/address
   input wire logic link_clk_in,
   input wire logic chip_sel_n_in,
   input wire logic [`SBAT_CA_W-1:0] cmd_addr_bus_rise_in,
   input wire logic [`SBAT_CA_W-1:0] cmd_addr_bus_fall_in,
   // Link data and strobe
   input wire logic [`SBAT_PAIR_W-1:0] dq_in,
   output logic [`SBAT_PAIR_W-1:0] dq_out,
   output logic dq_oe_out,
   input wire logic dqs_in,
   output logic dqs_out,
   output logic dqs_oe_out
);
   // Core domain state
   logic cfg_wl_b_ff;
   logic err_tgl_core;
   logic err_seen_ff;
   logic [`SBAT_BANKS-1:0] bank_open_core;

   // Link domain state
   logic link_rst;
   logic wl_b_link;
   sbat_cmd_t cmd;
   sbat_bank_t bank_sel;
   sbat_col_t col_addr;
   sbat_grp_t col_grp;
   logic [`SBAT_BANKS-1:0] bank_open;
   logic [`SBAT_BANKS-1:0] bank_ready;
   logic rd_busy;
   logic wr_busy;
   logic acc_ok;
   logic rd_go;
   logic wr_go;
   logic cmd_bad;
   logic err_tgl_ff;
   logic [`SBAT_RL-1:0] rd_vld_ff;
   logic [`SBAT_WL_B-1:0] wr_vld_ff;
   sbat_maddr_t addr_ff [`SBAT_RL];
   logic [`SBAT_WORD_W-1:0] mem_ff [`SBAT_MEM_DEPTH];

   // Read engine
   sbat_rd_state_t rd_st_ff;
   sbat_beat_t rd_cnt_ff;
   logic [`SBAT_WORD_W-1:0] rd_word_ff;
   logic [`SBAT_WORD_W-1:0] rd_word;
   logic rd_pre;
   logic rd_start;

   // Write engine
   logic wr_arm;
   sbat_maddr_t wr_arm_addr;
   logic wr_act_ff;
   sbat_beat_t wr_cnt_ff;
   sbat_maddr_t wr_addr_ff;
   logic [`SBAT_WORD_W-1:0] wr_word_ff;
   logic dqs_prev_ff;
   logic wr_cap;

   // ---------------- Core domain ----------------
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cfg_wl_b_ff <= 1'b0;
      end else begin
         cfg_wl_b_ff <= wl_set_b_in;
      end
   end

   sbat_sync #(.W(`SBAT_BANKS)) u_open_sync (
      .clk_in(core_clk_in),
      .d_in(bank_open),
      .q_out(bank_open_core)
   );

   sbat_sync #(.W(1)) u_err_sync (
      .clk_in(core_clk_in),
      .d_in(err_tgl_ff),
      .q_out(err_tgl_core)
   );

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         bank_open_out <= '0;
      end else begin
         bank_open_out <= bank_open_core;
      end
   end

   // Counts refused column commands reported by the link side
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         err_seen_ff <= 1'b0;
         proto_err_cnt_out <= '0;
      end else begin
         err_seen_ff <= err_tgl_core;
         if (err_tgl_core != err_seen_ff) begin
            proto_err_cnt_out <= proto_err_cnt_out + 1'b1;
         end
      end
   end

   // ---------------- Crossings into the link domain ----------------
   sbat_sync #(.W(1)) u_rst_sync (
      .clk_in(link_clk_in),
      .d_in(sys_rst_in),
      .q_out(link_rst)
   );

   sbat_sync #(.W(1)) u_wl_sync (
      .clk_in(link_clk_in),
      .d_in(cfg_wl_b_ff),
      .q_out(wl_b_link)
   );

   // ---------------- Command decode ----------------
   always_comb begin
      cmd = SBAT_CMD_NOP;
      if (!chip_sel_n_in) begin
         if (!cmd_addr_bus_rise_in[`SBAT_CA_OP0] && cmd_addr_bus_rise_in[`SBAT_CA_OP1]) begin
            cmd = SBAT_CMD_ACT;
         end else if (cmd_addr_bus_rise_in[`SBAT_CA_OP0] &&
                      !cmd_addr_bus_rise_in[`SBAT_CA_OP1]) begin
            cmd = cmd_addr_bus_rise_in[`SBAT_CA_OP2] ? SBAT_CMD_RD : SBAT_CMD_WR;
         end else if (cmd_addr_bus_rise_in[`SBAT_CA_OP0] &&
                      cmd_addr_bus_rise_in[`SBAT_CA_OP1] &&
                      !cmd_addr_bus_rise_in[`SBAT_CA_OP2] &&
                      cmd_addr_bus_rise_in[`SBAT_CA_OP3]) begin
            cmd = SBAT_CMD_PRE;
         end
      end
   end

   assign bank_sel = cmd_addr_bus_rise_in[`SBAT_CA_BA_HI:`SBAT_CA_BA_LO];
   assign col_addr = {cmd_addr_bus_rise_in[`SBAT_CA_COLR_HI:`SBAT_CA_COLR_LO],
                      cmd_addr_bus_fall_in[`SBAT_CA_COLF_HI:`SBAT_CA_COLF_LO]};
   assign col_grp = col_addr[`SBAT_GRP_HI:`SBAT_GRP_LO];

   // ---------------- Banks ----------------
   genvar g;
   generate
      for (g = 0; g < `SBAT_BANKS; g = g + 1) begin : g_bank
         sbat_bank u_bank (
            .clk_in(link_clk_in),
            .rst_in(link_rst),
            .act_in((cmd == SBAT_CMD_ACT) && (bank_sel == sbat_bank_t'(g))),
            .pre_in((cmd == SBAT_CMD_PRE) && (cmd_addr_bus_rise_in[`SBAT_CA_AB] ||
                    (bank_sel == sbat_bank_t'(g)))),
            .open_out(bank_open[g]),
            .ready_out(bank_ready[g])
         );
      end
   endgenerate

   // ---------------- Column command acceptance ----------------
   // A column command inside the last burst's slot would interrupt it
   assign rd_busy = |rd_vld_ff[`SBAT_BURST_CYC-2:0];
   assign wr_busy = |wr_vld_ff[`SBAT_BURST_CYC-2:0];
   assign acc_ok = bank_ready[bank_sel];
   assign rd_go = (cmd == SBAT_CMD_RD) && acc_ok && !rd_busy;
   assign wr_go = (cmd == SBAT_CMD_WR) && acc_ok && !wr_busy;
   assign cmd_bad = ((cmd == SBAT_CMD_RD) && !rd_go) || ((cmd == SBAT_CMD_WR) && !wr_go);

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         err_tgl_ff <= 1'b0;
      end else begin
         err_tgl_ff <= err_tgl_ff ^ cmd_bad;
      end
   end

   // Latency pipelines: bit i set means a command was taken i+1 edges ago
   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         rd_vld_ff <= '0;
         wr_vld_ff <= '0;
      end else begin
         rd_vld_ff <= {rd_vld_ff[`SBAT_RL-2:0], rd_go};
         wr_vld_ff <= {wr_vld_ff[`SBAT_WL_B-2:0], wr_go};
      end
   end

   always_ff @(posedge link_clk_in) begin
      addr_ff[0] <= {bank_sel, col_grp};
   end

   genvar s;
   generate
      for (s = 1; s < `SBAT_RL; s = s + 1) begin : g_addr_pipe
         always_ff @(posedge link_clk_in) begin
            addr_ff[s] <= addr_ff[s-1];
         end
      end
   endgenerate

   // ---------------- Read burst engine ----------------
   assign rd_pre = rd_vld_ff[`SBAT_RL-2];
   assign rd_start = rd_vld_ff[`SBAT_RL-1];
   assign rd_word = mem_ff[addr_ff[`SBAT_RL-1]];

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         rd_st_ff <= SBAT_RD_IDLE;
         rd_cnt_ff <= '0;
         rd_word_ff <= '0;
         dq_out <= '0;
         dq_oe_out <= 1'b0;
         dqs_out <= 1'b0;
         dqs_oe_out <= 1'b0;
      end else begin
         case (rd_st_ff)
            SBAT_RD_IDLE: begin
               if (rd_pre) begin
                  rd_st_ff <= SBAT_RD_PREAMBLE;
                  dqs_oe_out <= 1'b1;
                  dqs_out <= 1'b0;
               end
            end
            SBAT_RD_PREAMBLE: begin
               if (rd_start) begin
                  rd_st_ff <= SBAT_RD_DATA;
                  rd_cnt_ff <= '0;
                  dq_out <= rd_word[`SBAT_PAIR_W-1:0];
                  rd_word_ff <= {{`SBAT_PAIR_W{1'b0}}, rd_word[`SBAT_WORD_W-1:`SBAT_PAIR_W]};
                  dq_oe_out <= 1'b1;
                  dqs_out <= 1'b1;
               end
            end
            SBAT_RD_DATA: begin
               if (rd_cnt_ff != `SBAT_BEAT_LAST) begin
                  rd_cnt_ff <= rd_cnt_ff + 1'b1;
                  dq_out <= rd_word_ff[`SBAT_PAIR_W-1:0];
                  rd_word_ff <= {{`SBAT_PAIR_W{1'b0}},
                                 rd_word_ff[`SBAT_WORD_W-1:`SBAT_PAIR_W]};
                  dqs_out <= ~dqs_out;
               end else if (rd_start) begin
                  // Back-to-back read: no preamble, strobe keeps toggling
                  rd_cnt_ff <= '0;
                  dq_out <= rd_word[`SBAT_PAIR_W-1:0];
                  rd_word_ff <= {{`SBAT_PAIR_W{1'b0}}, rd_word[`SBAT_WORD_W-1:`SBAT_PAIR_W]};
                  dqs_out <= 1'b1;
               end else if (rd_pre) begin
                  rd_st_ff <= SBAT_RD_PREAMBLE;
                  dq_oe_out <= 1'b0;
                  dqs_out <= 1'b0;
               end else begin
                  rd_st_ff <= SBAT_RD_IDLE;
                  dq_oe_out <= 1'b0;
                  dqs_out <= 1'b0;
                  dqs_oe_out <= 1'b0;
               end
            end
            default: begin
               rd_st_ff <= SBAT_RD_IDLE;
               dq_oe_out <= 1'b0;
               dqs_oe_out <= 1'b0;
            end
         endcase
      end
   end

   // ---------------- Write burst engine ----------------
   assign wr_arm = wl_b_link ? wr_vld_ff[`SBAT_WL_B-1] : wr_vld_ff[`SBAT_WL_A-1];
   assign wr_arm_addr = wl_b_link ? addr_ff[`SBAT_WL_B-1] : addr_ff[`SBAT_WL_A-1];
   assign wr_cap = wr_act_ff && (dqs_in != dqs_prev_ff);

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         dqs_prev_ff <= 1'b0;
      end else begin
         dqs_prev_ff <= dqs_in;
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         wr_act_ff <= 1'b0;
         wr_cnt_ff <= '0;
         wr_addr_ff <= '0;
      end else if (wr_arm) begin
         // A new write window opens as the previous one takes its last beat
         wr_act_ff <= 1'b1;
         wr_cnt_ff <= '0;
         wr_addr_ff <= wr_arm_addr;
      end else if (wr_cap) begin
         wr_cnt_ff <= wr_cnt_ff + 1'b1;
         if (wr_cnt_ff == `SBAT_BEAT_LAST) begin
            wr_act_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge link_clk_in) begin
      if (link_rst) begin
         wr_word_ff <= '0;
      end else if (wr_cap) begin
         wr_word_ff <= {dq_in, wr_word_ff[`SBAT_WORD_W-1:`SBAT_PAIR_W]};
      end
   end

   // Storage: one burst word per bank and column group
   always_ff @(posedge link_clk_in) begin
      if (wr_cap && (wr_cnt_ff == `SBAT_BEAT_LAST)) begin
         mem_ff[wr_addr_ff] <= {dq_in, wr_word_ff[`SBAT_WORD_W-1:`SBAT_PAIR_W]};
      end
   end
endmodule : sbat_top

`default_nettype wire

// File: sim/sbat_top_chk.sv
// Concurrent checks on the ports of the bank-access timing block
`timescale 1ns/1ps
`default_nettype none
`include "sbat_defs.svh"
module sbat_top_chk
   import sbat_pkg::*;
(
   // Core domain
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic wl_set_b_in,
   input wire logic [`SBAT_BANKS-1:0] bank_open_out,
   input wire logic [`SBAT_ERR_W-1:0] proto_err_cnt_out,
   // Link command/address
   input wire logic link_clk_in,
   input wire logic chip_sel_n_in,
   input wire logic [`SBAT_CA_W-1:0] cmd_addr_bus_rise_in,
   input wire logic [`SBAT_CA_W-1:0] cmd_addr_bus_fall_in,
   // Link data and strobe
   input wire logic [`SBAT_PAIR_W-1:0] dq_in,
   input wire logic [`SBAT_PAIR_W-1:0] dq_out,
   input wire logic dq_oe_out,
   input wire logic dqs_in,
   input wire logic dqs_out,
   input wire logic dqs_oe_out
);
   logic [7:0] open_ff;
   logic [2:0] rd_age_ff;
   wire logic [3:0] op = cmd_addr_bus_rise_in[3:0];
   wire sbat_bank_t ba = cmd_addr_bus_rise_in[9:7];
   wire logic act_c = !chip_sel_n_in && op[1:0] == 2'h2;
   wire logic rd_c = !chip_sel_n_in && op[2:0] == 3'h5;
   wire logic pre_c = !chip_sel_n_in && op == 4'hB;
   wire logic rd_ok = rd_c && open_ff[ba] && rd_age_ff == 3'h4;

   // Mirror of bank state and read spacing, so only accepted reads arm the checks
   always_ff @(posedge link_clk_in) begin
      if (sys_rst_in) begin
         open_ff <= 8'h00;
         rd_age_ff <= 3'h4;
      end else begin
         if (act_c)
            open_ff[ba] <= 1'h1;
         if (pre_c)
            open_ff <= cmd_addr_bus_rise_in[4] ? 8'h00 : open_ff & ~(8'h01 << ba);
         rd_age_ff <= rd_ok ? 3'h1 : (rd_age_ff == 3'h4 ? 3'h4 : rd_age_ff + 3'h1);
      end
   end

   a_rd_preamble: assert property (@(posedge link_clk_in)
      disable iff (sys_rst_in) rd_ok |-> ##10 (dqs_oe_out && !dqs_out))
      else $error("read preamble missing");
   a_rd_first_beat: assert property (@(posedge link_clk_in)
      disable iff (sys_rst_in) rd_ok |-> ##11 (dq_oe_out && dqs_out))
      else $error("first read beat late");
   a_rd_strobe_toggle: assert property (@(posedge link_clk_in)
      disable iff (sys_rst_in) rd_ok |-> ##12 !dqs_out ##1 dqs_out ##1 !dqs_out)
      else $error("read strobe not toggling");
   a_rd_burst_held: assert property (@(posedge link_clk_in)
      disable iff (sys_rst_in) rd_ok |-> ##11 dq_oe_out [*4])
      else $error("read burst cut short");
   a_oe_pair: assert property (@(posedge link_clk_in)
      disable iff (sys_rst_in) dq_oe_out |-> dqs_oe_out)
      else $error("data driven without strobe");
   a_rd_burst_end: assert property (@(posedge link_clk_in)
      disable iff (sys_rst_in) rd_ok ##4 !rd_ok |-> ##11 !dq_oe_out)
      else $error("read burst overran");
   a_err_step: assert property (@(posedge core_clk_in)
      disable iff (sys_rst_in) proto_err_cnt_out != $past(proto_err_cnt_out)
      |-> proto_err_cnt_out == $past(proto_err_cnt_out) + 8'h01)
      else $error("refusal count jumped");
   a_act_opens: assert property (@(posedge link_clk_in)
      disable iff (sys_rst_in) act_c |-> ##5 bank_open_out[$past(ba, 5)])
      else $error("activated bank not open");
   a_pre_all_closes: assert property (@(posedge link_clk_in)
      disable iff (sys_rst_in) pre_c && cmd_addr_bus_rise_in[4] |-> ##5 bank_open_out == 8'h00)
      else $error("banks open after precharge all");

   c_gapless_rd: cover property (@(posedge link_clk_in) rd_ok ##4 rd_ok);
   c_refused_rd: cover property (@(posedge link_clk_in) rd_c && !rd_ok);
   c_pre_all: cover property (@(posedge link_clk_in) pre_c && cmd_addr_bus_rise_in[4]);
endmodule : sbat_top_chk

bind sbat_top sbat_top_chk chk (.core_clk_in, .sys_rst_in, .wl_set_b_in, .bank_open_out,
   .proto_err_cnt_out, .link_clk_in, .chip_sel_n_in, .cmd_addr_bus_rise_in,
   .cmd_addr_bus_fall_in, .dq_in, .dq_out, .dq_oe_out, .dqs_in, .dqs_out, .dqs_oe_out);
`default_nettype wire

// File: sim/sbat_ctrl_model.sv
// Memory controller model driving commands, write data and strobe
`timescale 1ns/1ps
`default_nettype none
module sbat_ctrl_model
   import sbat_pkg::*;
(
   // Link clock
   input wire logic link_clk_in,
   // Towards the block
   output logic chip_sel_n_out,
   output logic [9:0] cmd_rise_out,
   output logic [9:0] cmd_fall_out,
   output logic [15:0] dq_out,
   output logic dqs_out
);
   initial begin
      chip_sel_n_out = 1'h1;
      cmd_rise_out = 10'h000;
      cmd_fall_out = 10'h000;
      dq_out = 16'h0000;
      dqs_out = 1'h0;
   end

   // One command on a rising edge, bus released on the next
   task automatic cmd(input logic [3:0] op, input sbat_bank_t b, input sbat_col_t c,
         input logic ab);
      @(posedge link_clk_in);
      chip_sel_n_out <= 1'h0;
      cmd_rise_out <= {b, c[10:9], ab, op};
      cmd_fall_out <= {c[8:0], 1'h0};
      @(posedge link_clk_in);
      chip_sel_n_out <= 1'h1;
      {cmd_rise_out, cmd_fall_out} <= ~{cmd_rise_out, cmd_fall_out};
   endtask : cmd

   // Write burst: strobe low by the write latency, then one toggle per beat
   task automatic wr(input sbat_bank_t b, input sbat_col_t c, input logic [63:0] w,
         input int wl, input bit rel);
      cmd(4'h1, b, c, 1'h0);
      dqs_out <= 1'h0;
      repeat (wl) @(posedge link_clk_in);
      for (int k = 0; k < 4; k++) begin
         dq_out <= w[16*k+:16];
         dqs_out <= ~k[0];
         @(posedge link_clk_in);
      end
      if (rel)
         dq_out <= ~dq_out;
   endtask : wr
endmodule : sbat_ctrl_model
`default_nettype wire

// File: sim/sbat_top_bench.sv
// Self-checking bench for the bank-access timing block
`timescale 1ns/1ps
`default_nettype none
`include "sbat_defs.svh"
module sbat_top_bench
   import sbat_pkg::*;
;
   logic core_clk, link_clk, rst, wl_b, chip_sel_n, dqs_w, dq_oe, dqs_r, dqs_oe;
   logic [9:0] ca_r, ca_f;
   logic [15:0] dq_w, dq_r;
   logic [7:0] open_b, err;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   // Resolved two-way lines
   wire logic [15:0] dq_bus = dq_oe ? dq_r : dq_w;
   wire logic dqs_bus = dqs_oe ? dqs_r : dqs_w;

   initial begin
      core_clk = 1'h0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      link_clk = 1'h0;
      #7;
      forever #24 link_clk = ~link_clk;
   end

   sbat_top uut (
      .core_clk_in(core_clk),
      .sys_rst_in(rst),
      .wl_set_b_in(wl_b),
      .bank_open_out(open_b),
      .proto_err_cnt_out(err),
      .link_clk_in(link_clk),
      .chip_sel_n_in(chip_sel_n),
      .cmd_addr_bus_rise_in(ca_r),
      .cmd_addr_bus_fall_in(ca_f),
      .dq_in(dq_bus),
      .dq_out(dq_r),
      .dq_oe_out(dq_oe),
      .dqs_in(dqs_bus),
      .dqs_out(dqs_r),
      .dqs_oe_out(dqs_oe)
   );
   sbat_ctrl_model ctl (
      .link_clk_in(link_clk),
      .chip_sel_n_out(chip_sel_n),
      .cmd_rise_out(ca_r),
      .cmd_fall_out(ca_f),
      .dq_out(dq_w),
      .dqs_out(dqs_w)
   );

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Read command, then preamble, four beats and optional release
   task automatic rd_chk(input sbat_bank_t b, input sbat_col_t c, input logic [63:0] w,
         input bit last);
      ctl.cmd(4'h5, b, c, 1'h0);
      repeat (9) @(posedge link_clk);
      #1 chk(16'({dqs_oe, dqs_r}), 16'h0002);
      for (int k = 0; k < 4; k++) begin
         @(posedge link_clk);
         #1 chk(dq_r, w[16*k+:16]);
         chk(16'({dq_oe, dqs_oe, dqs_r}), 16'({2'h3, ~k[0]}));
      end
      if (last) begin
         @(posedge link_clk);
         #1 chk(16'({dq_oe, dqs_oe}), 16'h0000);
      end
   endtask : rd_chk

   task automatic t_banks();
      for (int i = 0; i < 8; i++) begin
         ctl.cmd(4'h2, i[2:0], 11'h000, 1'h0);
         repeat (2) @(posedge link_clk);
      end
      repeat (6) @(posedge link_clk);
      #1 chk(16'(open_b), 16'h00FF);
      ctl.cmd(4'hB, 3'h3, 11'h000, 1'h0);
      repeat (6) @(posedge link_clk);
      #1 chk(16'(open_b), 16'h00F7);
      ctl.cmd(4'hB, 3'h0, 11'h000, 1'h1);
      repeat (6) @(posedge link_clk);
      #1 chk(16'(open_b), 16'h0000);
      $display("banks done");
   endtask : t_banks

   task automatic t_wr_rd();
      ctl.cmd(4'h2, 3'h0, 11'h000, 1'h0);
      ctl.cmd(4'h2, 3'h5, 11'h000, 1'h0);
      ctl.wr(3'h0, 11'h628, 64'h0123_4567_89AB_CDEF, `SBAT_WL_A, 1'h1);
      repeat (3) @(posedge link_clk);
      rd_chk(3'h0, 11'h628, 64'h0123_4567_89AB_CDEF, 1'h1);
      @(posedge core_clk);
      wl_b <= 1'h1;
      repeat (4) @(posedge link_clk);
      ctl.wr(3'h0, 11'h010, 64'hFEDC_BA98_7654_3210, `SBAT_WL_B, 1'h1);
      repeat (3) @(posedge link_clk);
      rd_chk(3'h0, 11'h010, 64'hFEDC_BA98_7654_3210, 1'h1);
      rd_chk(3'h0, 11'h628, 64'h0123_4567_89AB_CDEF, 1'h1);
      $display("write read done");
   endtask : t_wr_rd

   task automatic t_gapless();
      fork
         ctl.wr(3'h0, 11'h018, 64'h1111_2222_3333_4444, `SBAT_WL_B, 1'h0);
         begin
            repeat (4) @(posedge link_clk);
            ctl.wr(3'h5, 11'h018, 64'h5555_6666_7777_8888, `SBAT_WL_B, 1'h1);
         end
      join
      repeat (3) @(posedge link_clk);
      fork
         rd_chk(3'h0, 11'h018, 64'h1111_2222_3333_4444, 1'h0);
         begin
            repeat (4) @(posedge link_clk);
            rd_chk(3'h5, 11'h018, 64'h5555_6666_7777_8888, 1'h1);
         end
      join
      $display("gapless done");
   endtask : t_gapless

   task automatic t_refuse();
      logic [7:0] e0;
      e0 = err;
      ctl.cmd(4'h5, 3'h2, 11'h000, 1'h0);
      repeat (10) @(posedge link_clk);
      #1 chk(16'({dq_oe, dqs_oe}), 16'h0000);
      fork
         rd_chk(3'h0, 11'h628, 64'h0123_4567_89AB_CDEF, 1'h1);
         begin
            repeat (2) @(posedge link_clk);
            ctl.cmd(4'h5, 3'h5, 11'h018, 1'h0);
         end
      join
      repeat (8) @(posedge link_clk);
      #1 chk(16'(err), 16'(e0 + 8'h02));
      // Last write to bank 0 is long past; closing it leaves bank 5 as the only open bank
      ctl.cmd(4'hB, 3'h0, 11'h000, 1'h0);
      repeat (6) @(posedge link_clk);
      #1 chk(16'(open_b), 16'h0020);
      $display("refusals done");
   endtask : t_refuse

   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         $display("MISMATCH t=%0t timeout", $time);
         test_done();
      end
   end

   initial begin
      rst = 1'h1;
      wl_b = 1'h0;
      repeat (4) @(posedge link_clk);
      @(posedge core_clk);
      rst <= 1'h0;
      repeat (3) @(posedge link_clk);
      t_banks();
      t_wr_rd();
      t_gapless();
      t_refuse();
      test_done();
   end
endmodule : sbat_top_bench
`default_nettype wire
